// ==== bmr_boot_reset.sv ====
// Function
// - On the large package a 3-bit strap picks SPI slave, SPI master, 8-bit flash or no boot, top bit set is reserved.
// - On the small package a 2-bit strap picks SPI slave, SPI master, reserved or no boot.
// - The no-boot code skips loading and runs from internal ROM after reset.
// - A running reset resets core and peripherals, keeps PLL and SDRAM controller, and starts no boot.
// - The reset-out pin doubles as an input whose external low drive requests a running reset.
// - Scaling-capable parts hold a factory voltage code readable by software.
// - The voltage code goes to the regulator over the two-wire serial port, with no dedicated pins.
// - The voltage code exists only on parts rated for 450 MHz.
// - At power-up internal memory is loaded from the strap-selected source when it is SPI slave, SPI master or 8-bit flash.
`timescale 1ns/1ps
`default_nettype none
module bmr_boot_reset #(
  parameter bit WIDE_PACKAGE = 1'b1,
  parameter bit RATED_450 = 1'b1,
  // Factory code default is arbitrary; fuses set the real value.
  parameter logic [7:0] FACTORY_VCODE = 8'h5a
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [2:0] i_boot_select_straps_wide,
  input wire logic [1:0] i_boot_select_straps_narrow,
  input wire logic i_reset_out_running_reset_in,
  output logic o_reset_out_running_reset_out,
  output logic o_reset_out_running_reset_oe,
  input wire logic i_boot_done,
  output bmr_pkg::bmr_rst_t o_resets,
  output bmr_pkg::bmr_boot_t o_boot,
  output logic o_rom_exec,
  output logic o_boot_reserved,
  output logic [7:0] o_nominal_core_voltage_code,
  output logic o_static_voltage_scaling_present
);

  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  logic [2:0] wide_s;
  logic [1:0] narrow_s;
  logic run_pin_s;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_wide
      bmr_sync2 u_sw (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n_q),
        .i_ce(i_ce),
        .i_async(i_boot_select_straps_wide[g]),
        .o_sync(wide_s[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_narrow
      bmr_sync2 u_sn (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n_q),
        .i_ce(i_ce),
        .i_async(i_boot_select_straps_narrow[g]),
        .o_sync(narrow_s[g])
      );
    end
  endgenerate
  // Idle pin reads high; sync resets low so treat reset value as no request.
  bmr_sync2 u_srun (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n_q),
    .i_ce(i_ce),
    .i_async(~i_reset_out_running_reset_in),
    .o_sync(run_pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  bmr_pkg::bmr_src_t wide_src;
  bmr_pkg::bmr_src_t narrow_src;
  bmr_pkg::bmr_src_t dec_src;
  assign wide_src =
    wide_s[bmr_pkg::BMR_W_TOP_BIT] ? bmr_pkg::BMR_SRC_RESERVED :
    (wide_s == bmr_pkg::BMR_W_SPI_SLAVE) ? bmr_pkg::BMR_SRC_SPI_SLAVE :
    (wide_s == bmr_pkg::BMR_W_SPI_MASTER) ? bmr_pkg::BMR_SRC_SPI_MASTER :
    (wide_s == bmr_pkg::BMR_W_FLASH8) ? bmr_pkg::BMR_SRC_FLASH8 :
    bmr_pkg::BMR_SRC_NO_BOOT;
  assign narrow_src =
    (narrow_s == bmr_pkg::BMR_N_SPI_SLAVE) ? bmr_pkg::BMR_SRC_SPI_SLAVE :
    (narrow_s == bmr_pkg::BMR_N_SPI_MASTER) ? bmr_pkg::BMR_SRC_SPI_MASTER :
    (narrow_s == bmr_pkg::BMR_N_RESERVED) ? bmr_pkg::BMR_SRC_RESERVED :
    bmr_pkg::BMR_SRC_NO_BOOT;
  assign dec_src = WIDE_PACKAGE ? wide_src : narrow_src;

  ////////////////////////////////////////////////////////////////////////////
  // Straps need two edges to settle through the synchronisers before capture.
  typedef enum logic [2:0] {
    BMR_ST_SETTLE, BMR_ST_CAPTURE, BMR_ST_BOOT, BMR_ST_RUN, BMR_ST_RUNRST
  } bmr_state_t;
  bmr_state_t state_q;
  bmr_state_t state_d;
  logic [1:0] settle_q;
  bmr_pkg::bmr_src_t src_q;
  logic [bmr_pkg::BMR_RUN_CNT_W-1:0] run_cnt_q;
  logic run_req_q;

  wire run_edge = run_pin_s & ~run_req_q;
  wire is_loader = (src_q != bmr_pkg::BMR_SRC_NO_BOOT) &&
                   (src_q != bmr_pkg::BMR_SRC_RESERVED);
  wire run_done = (run_cnt_q ==
    bmr_pkg::BMR_RUN_CNT_W'(bmr_pkg::BMR_RUN_RST_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      BMR_ST_SETTLE: if (settle_q == 2'h3) state_d = BMR_ST_CAPTURE;
      BMR_ST_CAPTURE: state_d = BMR_ST_BOOT;
      BMR_ST_BOOT: begin
        if (!is_loader || i_boot_done) state_d = BMR_ST_RUN;
      end
      BMR_ST_RUN: if (run_edge) state_d = BMR_ST_RUNRST;
      BMR_ST_RUNRST: if (run_done) state_d = BMR_ST_RUN;
      default: state_d = BMR_ST_SETTLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= BMR_ST_SETTLE;
      settle_q <= 2'h0;
      src_q <= bmr_pkg::BMR_SRC_SPI_SLAVE;
      run_cnt_q <= '0;
      run_req_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      run_req_q <= run_pin_s;
      if (state_q == BMR_ST_SETTLE) settle_q <= settle_q + 2'h1;
      if (state_q == BMR_ST_CAPTURE) src_q <= dec_src;
      if (state_q == BMR_ST_RUNRST) begin
        run_cnt_q <= run_cnt_q + bmr_pkg::BMR_RUN_CNT_W'(1);
      end
      else run_cnt_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire in_reset = (state_q != BMR_ST_RUN) && (state_q != BMR_ST_BOOT);
  assign o_resets.core_rst = in_reset || (state_q == BMR_ST_BOOT);
  assign o_resets.periph_rst = (state_q == BMR_ST_SETTLE) ||
                               (state_q == BMR_ST_CAPTURE) ||
                               (state_q == BMR_ST_RUNRST);
  assign o_resets.pll_rst = (state_q == BMR_ST_SETTLE);
  assign o_resets.sdram_rst = (state_q == BMR_ST_SETTLE) ||
                              (state_q == BMR_ST_CAPTURE);
  assign o_boot.start = (state_q == BMR_ST_BOOT) && is_loader;
  assign o_boot.src = src_q;
  assign o_rom_exec = (state_q == BMR_ST_RUN) &&
                      (src_q == bmr_pkg::BMR_SRC_NO_BOOT);
  assign o_boot_reserved = (src_q == bmr_pkg::BMR_SRC_RESERVED);
  // Open drain: pull low while the core is held in reset, else release.
  assign o_reset_out_running_reset_out = 1'b0;
  assign o_reset_out_running_reset_oe = o_resets.core_rst;

  // Code is handed to software; it reaches the regulator via the two-wire
  // serial port, so there is no dedicated output pin for it.
  assign o_static_voltage_scaling_present = RATED_450;
  assign o_nominal_core_voltage_code = RATED_450 ? FACTORY_VCODE
                                                 : bmr_pkg::BMR_VCODE_RST;

  ////////////////////////////////////////////////////////////////////////////
  property p_run_keeps_pll;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (state_q == BMR_ST_RUNRST) |-> !o_resets.pll_rst && !o_resets.sdram_rst
      && !o_boot.start && o_resets.core_rst && o_resets.periph_rst;
  endproperty
  a_run_keeps_pll: assert property (p_run_keeps_pll)
    else $error("running reset touched pll or sdram");
  property p_run_len;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    ($rose(state_q == BMR_ST_RUNRST) && i_ce) |->
      ##[16:1000] (state_q == BMR_ST_RUN);
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("running reset length");
  sequence s_pin_low;
    i_ce && (state_q == BMR_ST_RUN) && run_edge;
  endsequence
  property p_pin_trig;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_pin_low |=> (state_q == BMR_ST_RUNRST);
  endproperty
  a_pin_trig: assert property (p_pin_trig)
    else $error("pin request missed");
  property p_hold_src;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (state_q != BMR_ST_CAPTURE) && (state_q != BMR_ST_SETTLE) |=>
      $stable(src_q);
  endproperty
  a_hold_src: assert property (p_hold_src)
    else $error("boot source changed");
  property p_wide_rsv;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    WIDE_PACKAGE && wide_s[2] |-> dec_src == bmr_pkg::BMR_SRC_RESERVED;
  endproperty
  a_wide_rsv: assert property (p_wide_rsv)
    else $error("wide reserved decode");
  property p_narrow_nb;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    !WIDE_PACKAGE && narrow_s == bmr_pkg::BMR_N_NO_BOOT |->
      dec_src == bmr_pkg::BMR_SRC_NO_BOOT;
  endproperty
  a_narrow_nb: assert property (p_narrow_nb)
    else $error("narrow no-boot decode");
  property p_no_boot;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (state_q == BMR_ST_BOOT) && i_ce && src_q == bmr_pkg::BMR_SRC_NO_BOOT
      |-> !o_boot.start ##1 o_rom_exec;
  endproperty
  a_no_boot: assert property (p_no_boot)
    else $error("no-boot did not go to rom");
  property p_vcode;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    !RATED_450 |-> o_nominal_core_voltage_code == bmr_pkg::BMR_VCODE_RST;
  endproperty
  a_vcode: assert property (p_vcode)
    else $error("voltage code on low-rate part");

endmodule : bmr_boot_reset
`default_nettype wire

// ==== bmr_pkg.sv ====
package bmr_pkg;

  typedef enum logic [2:0] {
    BMR_SRC_SPI_SLAVE,
    BMR_SRC_SPI_MASTER,
    BMR_SRC_FLASH8,
    BMR_SRC_NO_BOOT,
    BMR_SRC_RESERVED
  } bmr_src_t;

  localparam logic [2:0] BMR_W_SPI_SLAVE = 3'h0;
  localparam logic [2:0] BMR_W_SPI_MASTER = 3'h1;
  localparam logic [2:0] BMR_W_FLASH8 = 3'h2;
  localparam logic [2:0] BMR_W_NO_BOOT = 3'h3;
  localparam int BMR_W_TOP_BIT = 2;
  localparam logic [1:0] BMR_N_SPI_SLAVE = 2'h0;
  localparam logic [1:0] BMR_N_SPI_MASTER = 2'h1;
  localparam logic [1:0] BMR_N_RESERVED = 2'h2;
  localparam logic [1:0] BMR_N_NO_BOOT = 2'h3;

  localparam int BMR_VCODE_W = 8;
  localparam logic [7:0] BMR_VCODE_RST = 8'h00;
  localparam int BMR_RUN_RST_CYC = 16;
  localparam int BMR_RUN_CNT_W = 5;

  typedef struct packed {
    logic core_rst;
    logic periph_rst;
    logic pll_rst;
    logic sdram_rst;
  } bmr_rst_t;

  typedef struct packed {
    logic start;
    bmr_src_t src;
  } bmr_boot_t;

endpackage : bmr_pkg

// ==== bmr_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmr_sync2 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_async,
  output logic o_sync
);
  logic s1_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      s1_q <= i_async;
      o_sync <= s1_q;
    end
  end
endmodule : bmr_sync2
`default_nettype wire

// ==== bmr_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmr_far_model (
  input wire logic i_sys_clk,
  input wire logic i_start,
  input wire logic [3:0] i_delay,
  input wire logic i_pull_low,
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  output logic o_boot_done,
  output logic o_pin
);
  logic [4:0] wait_q = 5'h00;
  // The board pull-up wins only when nobody drives the wire low.
  assign o_pin = ((i_pin_oe && !i_pin_out) || i_pull_low) ? 1'b0 : 1'b1;
  // The loader answers each boot request once, after a chosen delay.
  assign o_boot_done = i_start && (wait_q == {1'b0, i_delay});
  always @(posedge i_sys_clk) begin
    wait_q <= i_start ? wait_q + 5'h01 : 5'h00;
  end
endmodule : bmr_far_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pull_low = 1'b0;
  logic ce = 1'b1;
  logic [2:0] wide = 3'h0;
  logic [1:0] narrow = 2'h0;
  logic [3:0] dly = 4'h0;
  logic [31:0] rng = 32'h5e55_36bd;
  int err_count = 0;
  int n_compared = 0;
  int ew, en, na, nb, bad, k;
  int exp_q[$];
  logic [2:0] keep;
  bmr_pkg::bmr_rst_t rs_a, rs_b;
  bmr_pkg::bmr_boot_t bt_a, bt_b;
  logic dn_a, dn_b, pin_a, pin_b, po_a, po_b, oe_a, oe_b;
  logic rom_a, rom_b, rsv_a, rsv_b, sp_a, sp_b;
  logic [7:0] vc_a, vc_b;
  // Arbitrary factory code; any value but BMR_VCODE_RST proves that it reaches the port.
  localparam logic [7:0] VCODE = 8'ha7;
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  bmr_boot_reset #(.WIDE_PACKAGE(1'b1), .RATED_450(1'b1),
    .FACTORY_VCODE(VCODE)) dut_u (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_ce(ce),
    .i_boot_select_straps_wide(wide), .i_boot_select_straps_narrow(narrow),
    .i_reset_out_running_reset_in(pin_a),
    .o_reset_out_running_reset_out(po_a), .o_reset_out_running_reset_oe(oe_a),
    .i_boot_done(dn_a), .o_resets(rs_a), .o_boot(bt_a), .o_rom_exec(rom_a),
    .o_boot_reserved(rsv_a), .o_nominal_core_voltage_code(vc_a),
    .o_static_voltage_scaling_present(sp_a));
  bmr_boot_reset #(.WIDE_PACKAGE(1'b0), .RATED_450(1'b0),
    .FACTORY_VCODE(VCODE)) dut_n (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_ce(ce),
    .i_boot_select_straps_wide(wide), .i_boot_select_straps_narrow(narrow),
    .i_reset_out_running_reset_in(pin_b),
    .o_reset_out_running_reset_out(po_b), .o_reset_out_running_reset_oe(oe_b),
    .i_boot_done(dn_b), .o_resets(rs_b), .o_boot(bt_b), .o_rom_exec(rom_b),
    .o_boot_reserved(rsv_b), .o_nominal_core_voltage_code(vc_b),
    .o_static_voltage_scaling_present(sp_b));
  bmr_far_model far_a (.i_sys_clk(clk), .i_start(bt_a.start), .i_delay(dly),
    .i_pull_low(pull_low), .i_pin_out(po_a), .i_pin_oe(oe_a),
    .o_boot_done(dn_a), .o_pin(pin_a));
  bmr_far_model far_b (.i_sys_clk(clk), .i_start(bt_b.start), .i_delay(dly),
    .i_pull_low(pull_low), .i_pin_out(po_b), .i_pin_oe(oe_b),
    .o_boot_done(dn_b), .o_pin(pin_b));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  function automatic int src_w(input int c);
    return (c > 3) ? 4 : c;
  endfunction : src_w
  function automatic int src_n(input int c);
    return (c == 2) ? 4 : c;
  endfunction : src_n
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic bail(input int n);
    if (n >= 30) begin
      err_count++;
      $display("mismatch wait expected done seen timeout");
      give_verdict();
    end
  endtask : bail
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      rng = xs(rng);
      rst_n <= 1'b0;
      wide <= i[2:0];
      narrow <= rng[1:0];
      dly <= rng[5:2];
      repeat (12) tick();
      @(posedge clk);
      rst_n <= 1'b1;
      k = 0;
      while (rs_a.sdram_rst !== 1'b0 && k < 30) begin tick(); k++; end
      bail(k);
      exp_q.push_back(src_w(i));
      exp_q.push_back(src_n(int'(narrow)));
      ew = exp_q.pop_front();
      en = exp_q.pop_front();
      chk("src_wide", 8'(ew), 8'(bt_a.src));
      chk("src_narrow", 8'(en), 8'(bt_b.src));
      chk("start_wide", 8'(ew < 3), 8'(bt_a.start));
      chk("start_narrow", 8'(en < 3), 8'(bt_b.start));
      k = 0;
      while ((rs_a.core_rst | rs_b.core_rst) !== 1'b0 && k < 30) begin
        tick();
        k++;
      end
      bail(k);
      chk("rom_wide", 8'(ew == 3), 8'(rom_a));
      chk("rom_narrow", 8'(en == 3), 8'(rom_b));
      chk("rsv_wide", 8'(ew == 4), 8'(rsv_a));
      chk("rsv_narrow", 8'(en == 4), 8'(rsv_b));
    end
    chk("vcode_fast", VCODE, vc_a);
    chk("svs_fast", 8'h01, 8'(sp_a));
    chk("vcode_slow", 8'h00, vc_b);
    chk("svs_slow", 8'h00, 8'(sp_b));
    keep = bt_a.src;
    // New straps now must be ignored: only a power-on reset samples them.
    @(posedge clk);
    wide <= ~wide;
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      pull_low <= 1'b1;
      na = 0;
      nb = 0;
      bad = 0;
      // The pin stays low far past one reset, so a repeat would show.
      repeat (40) begin
        tick();
        na += int'(rs_a.core_rst === 1'b1 && rs_a.periph_rst === 1'b1);
        nb += int'(rs_b.core_rst === 1'b1);
        bad += int'(rs_a.pll_rst !== 1'b0 || rs_a.sdram_rst !== 1'b0
          || bt_a.start !== 1'b0 || rs_b.pll_rst !== 1'b0);
      end
      chk("runrst_wide", 8'(bmr_pkg::BMR_RUN_RST_CYC), 8'(na));
      chk("runrst_narrow", 8'(bmr_pkg::BMR_RUN_RST_CYC), 8'(nb));
      chk("kept_domains", 8'h00, 8'(bad));
      chk("src_kept", 8'(keep), 8'(bt_a.src));
      @(posedge clk);
      pull_low <= 1'b0;
      repeat (4) tick();
    end
    // A low enable freezes the synchronisers too, so a held pin goes unseen.
    @(posedge clk);
    ce <= 1'b0;
    pull_low <= 1'b1;
    na = 0;
    repeat (10) begin
      tick();
      na += int'(rs_a.core_rst !== 1'b0 || rs_b.core_rst !== 1'b0);
    end
    chk("frozen", 8'h00, 8'(na));
    @(posedge clk);
    ce <= 1'b1;
    na = 0;
    nb = 0;
    repeat (40) begin
      tick();
      na += int'(rs_a.core_rst === 1'b1);
      nb += int'(rs_b.core_rst === 1'b1);
    end
    chk("ce_runrst_wide", 8'(bmr_pkg::BMR_RUN_RST_CYC), 8'(na));
    chk("ce_runrst_narrow", 8'(bmr_pkg::BMR_RUN_RST_CYC), 8'(nb));
    give_verdict();
  end
endmodule : tb
`default_nettype wire
